//--- hw/arb_map.vh
/*
 * Constants for the six-master bus arbiter: register indices, reset
 * values, field positions, master indices and retry timer settings.
 * Assumes inclusion by bare name from the arbiter design file.
 */
`ifndef ARB_MAP_VH
`define ARB_MAP_VH

// -----------------------------------------------------------------------
// Register indices on the plain register port
// -----------------------------------------------------------------------
`define ARB_ADDR_PRI_CTRL   4'h0
`define ARB_ADDR_PRI_EXT    4'h1
`define ARB_ADDR_ARB_CTRL   4'h2
`define ARB_ADDR_STATUS     4'h3
`define ARB_ADDR_MASK       4'h4

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define ARB_PRI_CTRL_RST    8'h04
`define ARB_PRI_EXT_RST     8'h00
`define ARB_ARB_CTRL_RST    8'h00

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define ARB_PC_B0_SEL       0
`define ARB_PC_B1_SEL       1
`define ARB_PC_B2A_SEL      2
`define ARB_PC_B2B_SEL      3
`define ARB_PC_ROT_LO       4
`define ARB_PC_ROT_HI       7
`define ARB_PX_B3_SEL       0
`define ARB_AC_GAT          0
`define ARB_AC_TMR_LO       1
`define ARB_AC_TMR_HI       2

// -----------------------------------------------------------------------
// Master indices
// -----------------------------------------------------------------------
`define ARB_M_INT           0
`define ARB_M_REQ0          1
`define ARB_M_HOST          2
`define ARB_M_REQ1          3
`define ARB_M_REQ2          4
`define ARB_M_REQ3          5
`define ARB_NMAST           6

// -----------------------------------------------------------------------
// Retry timer selections, in clocks
// -----------------------------------------------------------------------
`define ARB_TMR_16          7'h10
`define ARB_TMR_32          7'h20
`define ARB_TMR_64          7'h40
`define ARB_TMR_ZERO        7'h00
`define ARB_TMR_ONE         7'h01

`endif

//--- hw/arb_pci_arbiter.v
/*
 * Six-master bus arbiter with four fixed/rotating banks, lock handling,
 * buffer flush / guaranteed access sideband handshake and retry masking.
 * Assumes one clock, inputs synchronous to it, active-high request and
 * grant levels inside the chip (pin polarity handled outside).
 */
`timescale 1ns/1ps
`include "arb_map.vh"

module arb_pci_arbiter
(
    input  wire       REF_CLK_IN,
    input  wire       RESET_IN,
    input  wire [3:0] REG_ADDR_IN,
    input  wire [7:0] REG_WDATA_IN,
    input  wire       REG_WR_IN,
    input  wire       REG_RD_IN,
    output reg  [7:0] REG_RDATA_OUT,
    input  wire       HOST_BUS_REQUEST_IN,
    input  wire [3:0] EXT_REQ_IN,
    output wire       HOST_GNT_OUT,
    output wire [3:0] EXT_GNT_OUT,
    output wire       INTERNAL_GNT_OUT,
    input  wire       INTERNAL_BUS_REQUEST_IN,
    input  wire       FRAME_ACTIVE_IN,
    input  wire       LOCK_ACTIVE_IN,
    input  wire       TARGET_RETRY_IN,
    input  wire       FOREIGN_RETRY_IN,
    input  wire       BUF_MGMT_BUSY_IN,
    input  wire       PWB_FULL_IN,
    input  wire       LOCKED_RESOURCE_IN,
    output wire       RETRY_OUT,
    output wire       RESUME_OUT,
    input  wire       ISA_DREQ_IN,
    input  wire       ISA_OWN_DONE_IN,
    output wire       OWN_BUF_FLUSH_OUT,
    output reg        DACK_OUT,
    output wire       BUFFER_FLUSH_REQUEST_N_OUT,
    output wire       MEMORY_ACCESS_REQUEST_N_OUT,
    input  wire       MEMORY_ACCESS_ACK_N_IN
);

// -----------------------------------------------------------------------
// Registers
// -----------------------------------------------------------------------
reg  [7:0] pri_ctrl_r;
reg  [7:0] pri_ext_r;
reg  [7:0] arb_ctrl_r;
reg  [4:0] bank_st_r;
reg  [5:0] gnt_r;
reg  [2:0] gnt_idx_r;
reg  [5:0] res_mask_r;
reg  [5:0] tmr_mask_r;
reg  [6:0] tmr_cnt_r;
reg        lock_own_r;
reg  [2:0] lock_idx_r;
reg        retry_cond_r;
reg        resume_r;
reg  [1:0] isa_st_r;

localparam [1:0] ISA_IDLE = 2'b00;
localparam [1:0] ISA_WACK = 2'b01;
localparam [1:0] ISA_WGNT = 2'b10;
localparam [1:0] ISA_OWN  = 2'b11;

wire       gat_en     = arb_ctrl_r[`ARB_AC_GAT];
wire [1:0] tmr_sel    = arb_ctrl_r[`ARB_AC_TMR_HI:`ARB_AC_TMR_LO];
wire [3:0] rot_en     = pri_ctrl_r[`ARB_PC_ROT_HI:`ARB_PC_ROT_LO];
wire       isa_busy   = (isa_st_r != ISA_IDLE);
wire       int_req    = INTERNAL_BUS_REQUEST_IN | (isa_st_r == ISA_WGNT);

// Raw requests by master index, then masking
wire [5:0] req_raw = {EXT_REQ_IN[3], EXT_REQ_IN[2], EXT_REQ_IN[1],
                      HOST_BUS_REQUEST_IN, EXT_REQ_IN[0], int_req};
wire [5:0] req_eff = req_raw & ~res_mask_r & ~tmr_mask_r;

// -----------------------------------------------------------------------
// Bank selects: fixed bit, or rotation state when rotating
// -----------------------------------------------------------------------
// Bank 2 ranks three pairs, so its select and state are two bits wide
localparam [1:0] B2_PAIR0 = 2'b00;
localparam [1:0] B2_PAIR1 = 2'b01;
localparam [1:0] B2_PAIR3 = 2'b10;
wire       s0 = rot_en[0] ? bank_st_r[0] : pri_ctrl_r[`ARB_PC_B0_SEL];
wire       s1 = rot_en[1] ? bank_st_r[1] : pri_ctrl_r[`ARB_PC_B1_SEL];
wire [1:0] s2 = rot_en[2] ? bank_st_r[3:2]
                          : pri_ctrl_r[`ARB_PC_B2B_SEL:`ARB_PC_B2A_SEL];
wire       s3 = rot_en[3] ? bank_st_r[4] : pri_ext_r[`ARB_PX_B3_SEL];

// Six-slot priority order, slot 0 highest, entry is master index
function [17:0] order_of;
    input       a0;
    input       a1;
    input [1:0] a2;
    input       a3;
    reg   [5:0] p0;
    reg   [5:0] p1;
    reg   [5:0] p3;
    begin
        p0 = a0 ? {3'd`ARB_M_REQ0, 3'd`ARB_M_INT} : {3'd`ARB_M_INT, 3'd`ARB_M_REQ0};
        p1 = a1 ? {3'd`ARB_M_REQ1, 3'd`ARB_M_HOST} : {3'd`ARB_M_HOST, 3'd`ARB_M_REQ1};
        p3 = a3 ? {3'd`ARB_M_REQ3, 3'd`ARB_M_REQ2} : {3'd`ARB_M_REQ2, 3'd`ARB_M_REQ3};
        // Reserved bank 2 code falls back to bank 0 pair first
        case (a2)
            B2_PAIR1: order_of = {p1, p0, p3};
            B2_PAIR3: order_of = {p3, p1, p0};
            default:  order_of = {p0, p3, p1};
        endcase
    end
endfunction

wire [17:0] ord = order_of(s0, s1, s2, s3);

// -----------------------------------------------------------------------
// Winner selection
// -----------------------------------------------------------------------
reg [2:0] win_idx;
reg       win_vld;
integer   k;
always @*
begin
    win_idx = 3'd0;
    win_vld = 1'b0;
    for (k = 0; k < `ARB_NMAST; k = k + 1)
    begin
        // Idle leader skipped; winner's bank still toggles and bank 2 still steps
        if (!win_vld && req_eff[ord[17 - 3*k -: 3]])
        begin
            win_idx = ord[17 - 3*k -: 3];
            win_vld = 1'b1;
        end
    end
    if (lock_own_r && req_raw[lock_idx_r])
    begin
        win_idx = lock_idx_r;
        win_vld = 1'b1;
    end
end

wire   bus_idle  = ~FRAME_ACTIVE_IN;
wire   gnt_rel   = (gnt_r == 6'h00) || ((gnt_r & req_eff) == 6'h00);
wire   reeval    = bus_idle && gnt_rel;
wire [5:0] win_oh = win_vld ? (6'h01 << win_idx) : 6'h00;

assign INTERNAL_GNT_OUT = gnt_r[`ARB_M_INT];
assign HOST_GNT_OUT     = gnt_r[`ARB_M_HOST];
assign EXT_GNT_OUT      = {gnt_r[`ARB_M_REQ3], gnt_r[`ARB_M_REQ2],
                           gnt_r[`ARB_M_REQ1], gnt_r[`ARB_M_REQ0]};

// Two-input bank owning a master: {bank 3, bank 1, bank 0}
function [2:0] toggles_of;
    input [2:0] m;
    begin
        case (m)
            3'd`ARB_M_INT, 3'd`ARB_M_REQ0:  toggles_of = 3'b001;
            3'd`ARB_M_HOST, 3'd`ARB_M_REQ1: toggles_of = 3'b010;
            default:                        toggles_of = 3'b100;
        endcase
    end
endfunction

// Bank 2 steps on every grant, whichever pair won
wire [2:0] tg          = toggles_of(win_idx);
wire [1:0] b2_step     = (bank_st_r[3:2] == B2_PAIR0) ? B2_PAIR3 :
                         (bank_st_r[3:2] == B2_PAIR3) ? B2_PAIR1 : B2_PAIR0;
wire [4:0] bank_st_nxt = {bank_st_r[4] ^ (tg[2] & rot_en[3]),
                          rot_en[2] ? b2_step : bank_st_r[3:2],
                          bank_st_r[1:0] ^ (tg[1:0] & rot_en[1:0])};

always @(posedge REF_CLK_IN or posedge RESET_IN)
begin
    if (RESET_IN)
    begin
        gnt_r      <= 6'h00;
        gnt_idx_r  <= 3'h0;
        bank_st_r  <= 5'h00;
        lock_own_r <= 1'b0;
        lock_idx_r <= 3'd0;
    end
    else
    begin
        if (reeval)
        begin
            gnt_r <= win_oh;
            // Rotation advances only on a real grant
            gnt_idx_r <= win_idx;
            if (win_vld)
                bank_st_r <= bank_st_nxt;
        end
        if (LOCK_ACTIVE_IN && gnt_r != 6'h00 && !lock_own_r)
        begin
            lock_own_r <= 1'b1;
            lock_idx_r <= gnt_idx_r;
        end
        else if (!LOCK_ACTIVE_IN && !FRAME_ACTIVE_IN)
            lock_own_r <= 1'b0;
    end
end

// -----------------------------------------------------------------------
// Flush / guaranteed access handshake
// -----------------------------------------------------------------------
wire mem_ack = ~MEMORY_ACCESS_ACK_N_IN;
always @(posedge REF_CLK_IN or posedge RESET_IN)
begin
    if (RESET_IN)
    begin
        isa_st_r <= ISA_IDLE;
        DACK_OUT <= 1'b0;
    end
    else
    begin
        case (isa_st_r)
            ISA_IDLE:
                if (ISA_DREQ_IN)
                    isa_st_r <= ISA_WACK;
            ISA_WACK:
                if (mem_ack)
                begin
                    if (gat_en)
                        isa_st_r <= ISA_WGNT;
                    else
                    begin
                        isa_st_r <= ISA_OWN;
                        DACK_OUT <= 1'b1;
                    end
                end
            ISA_WGNT:
                if (gnt_r[`ARB_M_INT])
                begin
                    isa_st_r <= ISA_OWN;
                    DACK_OUT <= 1'b1;
                end
            default:
                if (ISA_OWN_DONE_IN)
                begin
                    isa_st_r <= ISA_IDLE;
                    DACK_OUT <= 1'b0;
                end
        endcase
    end
end

// Memory request only ever alongside flush request
assign BUFFER_FLUSH_REQUEST_N_OUT  = ~isa_busy;
assign MEMORY_ACCESS_REQUEST_N_OUT = ~(isa_busy & gat_en);
assign OWN_BUF_FLUSH_OUT           = (isa_st_r == ISA_WACK);

// -----------------------------------------------------------------------
// Retry masking, resume and retry timer
// -----------------------------------------------------------------------
wire retry_cond = BUF_MGMT_BUSY_IN | isa_busy | PWB_FULL_IN
                | (LOCKED_RESOURCE_IN & LOCK_ACTIVE_IN);
assign RETRY_OUT  = retry_cond;
assign RESUME_OUT = resume_r;

reg [6:0] tmr_len;
always @*
begin
    case (tmr_sel)
        2'b01:   tmr_len = `ARB_TMR_16;
        2'b10:   tmr_len = `ARB_TMR_32;
        2'b11:   tmr_len = `ARB_TMR_64;
        default: tmr_len = `ARB_TMR_ZERO;
    endcase
end

wire tmr_on     = (tmr_sel != 2'b00);
wire tmr_expire = (tmr_cnt_r == `ARB_TMR_ONE);
wire others_idle = ((req_raw & ~tmr_mask_r) == 6'h00);
wire [5:0] gnt_mask = gnt_r;

always @(posedge REF_CLK_IN or posedge RESET_IN)
begin
    if (RESET_IN)
    begin
        res_mask_r   <= 6'h00;
        tmr_mask_r   <= 6'h00;
        tmr_cnt_r    <= `ARB_TMR_ZERO;
        retry_cond_r <= 1'b0;
        resume_r     <= 1'b0;
    end
    else
    begin
        retry_cond_r <= retry_cond;
        resume_r     <= retry_cond_r & ~retry_cond;
        // New mask wins over a clear in the same cycle
        if (resume_r)
            res_mask_r <= (TARGET_RETRY_IN ? gnt_mask : 6'h00);
        else if (TARGET_RETRY_IN)
            res_mask_r <= res_mask_r | gnt_mask;
        if (FOREIGN_RETRY_IN && tmr_on)
        begin
            tmr_mask_r <= (tmr_expire ? 6'h00 : tmr_mask_r) | gnt_mask;
            if (tmr_cnt_r == `ARB_TMR_ZERO || tmr_expire)
                tmr_cnt_r <= tmr_len;
        end
        else if (tmr_expire || (others_idle && tmr_mask_r != 6'h00))
        begin
            tmr_mask_r <= 6'h00;
            tmr_cnt_r  <= `ARB_TMR_ZERO;
        end
        else if (tmr_cnt_r != `ARB_TMR_ZERO)
            tmr_cnt_r <= tmr_cnt_r - `ARB_TMR_ONE;
    end
end

// -----------------------------------------------------------------------
// Register port
// -----------------------------------------------------------------------
always @(posedge REF_CLK_IN or posedge RESET_IN)
begin
    if (RESET_IN)
    begin
        pri_ctrl_r    <= `ARB_PRI_CTRL_RST;
        pri_ext_r     <= `ARB_PRI_EXT_RST;
        arb_ctrl_r    <= `ARB_ARB_CTRL_RST;
        REG_RDATA_OUT <= 8'h00;
    end
    else
    begin
        REG_RDATA_OUT <= 8'h00;
        if (REG_WR_IN)
        begin
            if (REG_ADDR_IN == `ARB_ADDR_PRI_CTRL)
                pri_ctrl_r <= REG_WDATA_IN;
            else if (REG_ADDR_IN == `ARB_ADDR_PRI_EXT)
                pri_ext_r <= {7'h00, REG_WDATA_IN[`ARB_PX_B3_SEL]};
            else if (REG_ADDR_IN == `ARB_ADDR_ARB_CTRL)
                arb_ctrl_r <= {5'h00, REG_WDATA_IN[2:0]};
        end
        if (REG_RD_IN)
        begin
            if (REG_ADDR_IN == `ARB_ADDR_PRI_CTRL)
                REG_RDATA_OUT <= pri_ctrl_r;
            else if (REG_ADDR_IN == `ARB_ADDR_PRI_EXT)
                REG_RDATA_OUT <= pri_ext_r;
            else if (REG_ADDR_IN == `ARB_ADDR_ARB_CTRL)
                REG_RDATA_OUT <= arb_ctrl_r;
            else if (REG_ADDR_IN == `ARB_ADDR_STATUS)
                REG_RDATA_OUT <= {isa_st_r, lock_own_r, bank_st_r};
            else if (REG_ADDR_IN == `ARB_ADDR_MASK)
                REG_RDATA_OUT <= {2'b00, res_mask_r | tmr_mask_r};
        end
    end
end

endmodule

//--- verif/arb_sys_model.sv
/* System side of the flush / memory handshake: answers with one
   acknowledge after a set flush time. Assumes the arbiter's clock. */
`timescale 1ns/1ps
module arb_sys_model
(
    input  wire       REF_CLK_IN,
    input  wire       RESET_IN,
    input  wire       FLUSH_REQ_N_IN,
    input  wire [3:0] DELAY_IN,
    output reg        ACK_N_OUT
);
    reg [3:0] wait_r;
    always @(posedge REF_CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            wait_r    <= 4'h0;
            ACK_N_OUT <= 1'b1;
        end
        else if (FLUSH_REQ_N_IN)
        begin
            wait_r    <= 4'h0;
            ACK_N_OUT <= 1'b1;
        end
        else if (wait_r == DELAY_IN)
            ACK_N_OUT <= 1'b0;         // Buffers stay off while held
        else
            wait_r <= wait_r + 4'h1;   // Flush time before answering
    end
endmodule

//--- verif/arb_pci_arbiter_assertions.sv
/* Port checker for the arbiter: grants, sideband handshake, retry.
   Assumes one clock and the active-high reset of the design. */
`timescale 1ns/1ps
module arb_chk
(
    input wire       REF_CLK_IN,
    input wire       RESET_IN,
    input wire       HOST_GNT_OUT,
    input wire [3:0] EXT_GNT_OUT,
    input wire       INTERNAL_GNT_OUT,
    input wire       HOST_BUS_REQUEST_IN,
    input wire       BUF_MGMT_BUSY_IN,
    input wire       RETRY_OUT,
    input wire       RESUME_OUT,
    input wire       ISA_DREQ_IN,
    input wire       DACK_OUT,
    input wire       BUFFER_FLUSH_REQUEST_N_OUT,
    input wire       MEMORY_ACCESS_REQUEST_N_OUT,
    input wire       MEMORY_ACCESS_ACK_N_IN
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire flush_a = !BUFFER_FLUSH_REQUEST_N_OUT;
    wire mem_a   = !MEMORY_ACCESS_REQUEST_N_OUT;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    a_mem_has_flush: assert property (mem_a |-> flush_a)
        else $error("memory request without flush");
    a_one_grant: assert property ($onehot0({HOST_GNT_OUT, EXT_GNT_OUT, INTERNAL_GNT_OUT}))
        else $error("more than one grant");
    a_grant_held: assert property (HOST_GNT_OUT && HOST_BUS_REQUEST_IN |=> HOST_GNT_OUT)
        else $error("grant dropped while requested");
    a_dreq_flush: assert property (!flush_a && !DACK_OUT && ISA_DREQ_IN |=> flush_a)
        else $error("no flush after isa request");
    a_dack_after_ack: assert property ($rose(DACK_OUT) |-> !$past(MEMORY_ACCESS_ACK_N_IN))
        else $error("dack before acknowledge");
    a_dack_flush: assert property (DACK_OUT |-> flush_a)
        else $error("flush released during ownership");
    a_gat_dack_gnt: assert property ($rose(DACK_OUT) && mem_a |-> $past(INTERNAL_GNT_OUT))
        else $error("guaranteed dack without bus grant");
    a_retry_busy: assert property (BUF_MGMT_BUSY_IN |-> RETRY_OUT)
        else $error("no retry during buffer work");
    a_resume_one: assert property (RESUME_OUT |=> !RESUME_OUT)
        else $error("resume longer than one clock");
    a_resume_cause: assert property (RESUME_OUT |-> $past(RETRY_OUT) || $past(RETRY_OUT, 2))
        else $error("resume without retry");
    c_gat_dack: cover property ($rose(DACK_OUT) && mem_a);
    c_resume: cover property (RESUME_OUT);
    c_host_gnt: cover property ($rose(HOST_GNT_OUT));
endmodule
bind arb_pci_arbiter arb_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
    .HOST_GNT_OUT(HOST_GNT_OUT), .EXT_GNT_OUT(EXT_GNT_OUT), .INTERNAL_GNT_OUT(INTERNAL_GNT_OUT),
    .HOST_BUS_REQUEST_IN(HOST_BUS_REQUEST_IN), .BUF_MGMT_BUSY_IN(BUF_MGMT_BUSY_IN),
    .RETRY_OUT(RETRY_OUT), .RESUME_OUT(RESUME_OUT), .ISA_DREQ_IN(ISA_DREQ_IN),
    .DACK_OUT(DACK_OUT), .BUFFER_FLUSH_REQUEST_N_OUT(BUFFER_FLUSH_REQUEST_N_OUT),
    .MEMORY_ACCESS_REQUEST_N_OUT(MEMORY_ACCESS_REQUEST_N_OUT),
    .MEMORY_ACCESS_ACK_N_IN(MEMORY_ACCESS_ACK_N_IN));

//--- verif/tb_arb_pci_arbiter.sv
/* Self-checking bench for the arbiter: registers, fixed and rotating
   priority, lock, retry masking and the flush handshake.
   Assumes the design and the system model compiled before it. */
`timescale 1ns/1ps
module tb_arb_pci_arbiter;
    reg        clk, rst, wr, rd, frame, lock, tretry, fretry, busy, full, dreq, done;
    reg  [3:0] addr, dly, c;
    reg  [7:0] wdata, d;
    reg  [5:0] req, seen;
    reg [31:0] r;
    wire [7:0] rdata;
    wire [3:0] eg;
    wire       hg, ig, retry, resume, oflush, dack, fl_n, mem_n, ack_n;
    wire [5:0] g   = {eg[3], eg[2], eg[1], hg, eg[0], ig};
    wire [4:0] mon = {resume, dack, fl_n, |g, |(g & req)};
    integer    seed, bad_count, checks_done, i, n;

    arb_pci_arbiter dut (.REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .HOST_BUS_REQUEST_IN(req[2]), .EXT_REQ_IN({req[5], req[4], req[3], req[1]}),
        .HOST_GNT_OUT(hg), .EXT_GNT_OUT(eg), .INTERNAL_GNT_OUT(ig),
        .INTERNAL_BUS_REQUEST_IN(req[0]), .FRAME_ACTIVE_IN(frame), .LOCK_ACTIVE_IN(lock),
        .TARGET_RETRY_IN(tretry), .FOREIGN_RETRY_IN(fretry), .BUF_MGMT_BUSY_IN(busy),
        .PWB_FULL_IN(full), .LOCKED_RESOURCE_IN(1'b0), .RETRY_OUT(retry),
        .RESUME_OUT(resume), .ISA_DREQ_IN(dreq), .ISA_OWN_DONE_IN(done),
        .OWN_BUF_FLUSH_OUT(oflush), .DACK_OUT(dack), .BUFFER_FLUSH_REQUEST_N_OUT(fl_n),
        .MEMORY_ACCESS_REQUEST_N_OUT(mem_n), .MEMORY_ACCESS_ACK_N_IN(ack_n));
    arb_sys_model sys (.REF_CLK_IN(clk), .RESET_IN(rst), .FLUSH_REQ_N_IN(fl_n),
        .DELAY_IN(dly), .ACK_N_OUT(ack_n));

    // ------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task chk_vec(input [7:0] v, input [7:0] e);
    begin
        checks_done = checks_done + 1;
        if (v !== e)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t value %h expected %h", $time, v, e);
        end
    end
    endtask
    task chk_bit(input v, input e);
    begin
        chk_vec({7'h0, v}, {7'h0, e});
    end
    endtask
    task wr_reg(input [3:0] a, input [7:0] v);
    begin
        @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    end
    endtask
    task rd_reg(input [3:0] a);
    begin
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 d = rdata;
    end
    endtask
    // Bounded wait on one monitored flag
    task wait_on(input [2:0] k, input v);
    begin
        n = 0;
        @(posedge clk); #1;
        while (mon[k] !== v)
        begin
            n = n + 1;
            if (n > 300)
            begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t wait ran out", $time);
                complete_run;
            end
            @(posedge clk); #1;
        end
    end
    endtask
    // Highest requesting master for a fixed bank code
    function [2:0] top_of(input [4:0] cd, input [5:0] rq);
        reg [5:0]  a, b, e;
        reg [17:0] l;
        integer    k;
        begin
            a = cd[0] ? {3'h1, 3'h0} : {3'h0, 3'h1};
            b = cd[1] ? {3'h3, 3'h2} : {3'h2, 3'h3};
            e = cd[4] ? {3'h5, 3'h4} : {3'h4, 3'h5};
            l = cd[3] ? {e, b, a} : (cd[2] ? {b, a, e} : {a, e, b});
            top_of = 3'h7;
            for (k = 0; k < 6; k = k + 1)
                if (rq[l[k*3 +: 3]])
                    top_of = l[k*3 +: 3];
        end
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 98259; bad_count = 0; checks_done = 0; addr = 4'h0; wdata = 8'h00;
        wr = 0; rd = 0; req = 6'h00; frame = 0; lock = 0; tretry = 0; fretry = 0;
        busy = 0; full = 0; dreq = 0; done = 0; dly = 4'h1; rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h0); chk_vec(d, 8'h04);
        rd_reg(4'h1); chk_vec(d, 8'h00);
        rd_reg(4'hF); chk_vec(d, 8'h00);
        @(posedge clk); req <= 6'h3F;
        wait_on(3'h0, 1'b1); chk_vec({2'h0, g}, 8'h04);
        @(posedge clk); req <= 6'h00;
        wait_on(3'h1, 1'b0);
        $display("test reset done");
        for (i = 0; i < 28; i = i + 1)
        begin
            r = $random(seed);
            c = (i < 12) ? i[3:0] : (r[3] ? {2'h2, r[1:0]} : {1'b0, r[2:0]});
            wr_reg(4'h0, {4'h0, c});
            wr_reg(4'h1, {7'h00, r[10]});
            @(posedge clk); req <= (r[9:4] == 6'h00) ? 6'h10 : r[9:4];
            wait_on(3'h0, 1'b1); chk_vec({2'h0, g}, 8'h01 << top_of({r[10], c}, req));
            @(posedge clk); req <= 6'h00;
            wait_on(3'h1, 1'b0);
        end
        $display("test fixed done");
        wr_reg(4'h0, 8'hF0); wr_reg(4'h1, 8'h01); seen = 6'h00;
        @(posedge clk); req <= 6'h3F;
        for (i = 0; i < 12; i = i + 1)
        begin
            wait_on(3'h0, 1'b1); seen = seen | g;
            @(posedge clk); req <= 6'h3F & ~g;
        end
        chk_vec({2'h0, seen}, 8'h3F);
        @(posedge clk); req <= 6'h00;
        wait_on(3'h1, 1'b0);
        wr_reg(4'h0, 8'h04); wr_reg(4'h1, 8'h00);
        $display("test rotate done");
        @(posedge clk); req <= 6'h20;
        wait_on(3'h0, 1'b1);
        @(posedge clk); frame <= 1'b1; lock <= 1'b1;
        @(posedge clk); frame <= 1'b0; req <= 6'h00;
        wait_on(3'h1, 1'b0);
        @(posedge clk); req <= 6'h24;
        wait_on(3'h0, 1'b1); chk_vec({2'h0, g}, 8'h20);
        @(posedge clk); req <= 6'h00; lock <= 1'b0;
        wait_on(3'h1, 1'b0);
        @(posedge clk); req <= 6'h24;
        wait_on(3'h0, 1'b1); chk_vec({2'h0, g}, 8'h04);
        @(posedge clk); req <= 6'h00;
        wait_on(3'h1, 1'b0);
        $display("test lock done");
        @(posedge clk); req <= 6'h08;
        wait_on(3'h0, 1'b1);
        @(posedge clk); tretry <= 1'b1; req <= 6'h00;
        @(posedge clk); tretry <= 1'b0;
        @(posedge clk); req <= 6'h08; // Released two clocks
        rd_reg(4'h4); chk_bit(|d, 1'b1); chk_bit(|g, 1'b0);
        @(posedge clk); full <= 1'b1;
        #1 chk_bit(retry, 1'b1);
        @(posedge clk); full <= 1'b0; busy <= 1'b1;
        #1 chk_bit(retry, 1'b1);
        @(posedge clk); busy <= 1'b0;
        wait_on(3'h4, 1'b1); wait_on(3'h0, 1'b1); chk_vec({2'h0, g}, 8'h08);
        @(posedge clk); req <= 6'h00;
        wait_on(3'h1, 1'b0);
        for (i = 1; i < 4; i = i + 1)
        begin
            wr_reg(4'h2, {5'h00, i[1:0], 1'b0});
            @(posedge clk); req <= 6'h08;
            wait_on(3'h0, 1'b1);
            @(posedge clk); fretry <= 1'b1; req <= 6'h04;
            @(posedge clk); fretry <= 1'b0;
            @(posedge clk); req <= 6'h0C;
            repeat (8 << (i - 1)) @(posedge clk);
            rd_reg(4'h4); chk_bit(|d, 1'b1);
            repeat ((8 << (i - 1)) + 8) @(posedge clk);
            rd_reg(4'h4); chk_bit(|d, 1'b0);
            @(posedge clk); req <= 6'h00;
            wait_on(3'h1, 1'b0);
        end
        $display("test retry done");
        for (i = 0; i < 2; i = i + 1)
        begin
            wr_reg(4'h2, {7'h00, i[0]});
            @(posedge clk); dreq <= 1'b1; dly <= i[0] ? 4'h6 : 4'h1;
            @(posedge clk); #1;
            chk_bit(fl_n, 1'b0); chk_bit(oflush, 1'b1);
            chk_bit(mem_n, ~i[0]);
            wait_on(3'h3, 1'b1); chk_bit(ack_n, 1'b0);
            chk_bit(retry, 1'b1); chk_bit(mem_n, ~i[0]);
            @(posedge clk); done <= 1'b1; dreq <= 1'b0;
            @(posedge clk); done <= 1'b0;
            wait_on(3'h2, 1'b1); chk_bit(dack, 1'b0); chk_bit(mem_n, 1'b1);
        end
        $display("test sideband done");
        complete_run;
    end
endmodule
